/* File: rtl/ibs_pkg.sv */
package ibs_pkg;
    // Slave count and fixed area size per slave, in 16-bit words.
    localparam int NSLV = 60;
    localparam int WPS = 16;
    localparam int AW = 10;
    localparam int SW = 6;
    localparam int DW = 16;
    localparam int FIFO_DEPTH = 8;
    // Value of every per-slave swap bit after reset.
    localparam logic SWAP_RST = 1'b0;
    // Area select of a host access.
    localparam logic AREA_IN = 1'b0;
    localparam logic AREA_OUT = 1'b1;
    // Kinds of host access.
    localparam logic [1:0] KIND_REFRESH = 2'h0;
    localparam logic [1:0] KIND_BLOCK = 2'h1;
    localparam logic [1:0] KIND_MOVE = 2'h2;
    localparam logic [1:0] KIND_DIRECT = 2'h3;
    // Output sender states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HOLD = 3'h2,
        ST_SEND = 3'h4
    } ibs_st_t;
endpackage : ibs_pkg

/* File: rtl/ibs_swap_lock.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with registered ready and valid.
module ibs_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Fill side.
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side.
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("ibs_fifo depth must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic in_ready;
        logic out_valid;
    } ibs_fifo_st_t;

    ibs_fifo_st_t q_r, q_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic push, pop;

    assign push = i_in_valid && q_r.in_ready;
    assign pop = q_r.out_valid && i_out_ready;
    assign o_in_ready = q_r.in_ready;
    assign o_out_valid = q_r.out_valid;
    assign o_out_data = mem_r[q_r.rp];

    // Pointer and count update; flags are registered from the next count.
    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.wp = q_r.wp + 1'b1;
        end
        if (pop) begin
            q_nxt.rp = q_r.rp + 1'b1;
        end
        q_nxt.cnt = q_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        q_nxt.in_ready = q_nxt.cnt != (PW+1)'(DEPTH);
        q_nxt.out_valid = q_nxt.cnt != '0;
    end

    // State register.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q_r <= '{wp: '0, rp: '0, cnt: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Storage.
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_r[q_r.wp] <= i_in_data;
        end
    end
endmodule : ibs_fifo

////////////////////////////////////////////////////////////////////////////////
// Operation
// (R1) Swap word bytes for swap-enabled slaves.
// (R2) One independent swap bit per slave.
// (R3) All swap bits cleared after reset.
// (R4) Host reorders mixed byte/word data itself.
// (R5) Bus and host sides run without timing assumptions.
// (R6) Protected input read waits for transfer end.
// (R7) Output send waits for host write end.
// (R8) Word-move and direct accesses never wait.
// (R9) Host enables refresh plus consistency option.
// (R10) Block commands refused while consistency enabled.
// (R11) Swap happens inside the protected transfer.
module ibs_swap_lock #(
    parameter int NSLV = ibs_pkg::NSLV,
    parameter int WPS = ibs_pkg::WPS
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Settings.
    input wire logic i_consist_en,
    input wire logic i_cfg_we,
    input wire logic [ibs_pkg::SW-1:0] i_cfg_slave,
    input wire logic i_cfg_swap,
    // Input words arriving from the bus.
    input wire logic i_bin_valid,
    input wire logic [ibs_pkg::SW-1:0] i_bin_slave,
    input wire logic [ibs_pkg::DW-1:0] i_bin_data,
    input wire logic i_bin_last,
    output logic o_bin_ready,
    // Output words leaving for the bus.
    input wire logic i_bout_req,
    input wire logic [ibs_pkg::SW-1:0] i_bout_slave,
    input wire logic i_bout_ready,
    output logic o_bout_valid,
    output logic [ibs_pkg::DW-1:0] o_bout_data,
    output logic o_bout_last,
    // Host buffer accesses.
    input wire logic i_hst_req,
    input wire logic [1:0] i_hst_kind,
    input wire logic i_hst_wr,
    input wire logic i_hst_area,
    input wire logic [ibs_pkg::AW-1:0] i_hst_addr,
    input wire logic [ibs_pkg::DW-1:0] i_hst_wdata,
    input wire logic i_hst_last,
    output logic o_hst_ack,
    output logic o_hst_err,
    output logic [ibs_pkg::DW-1:0] o_hst_rdata
);
    localparam int AW = ibs_pkg::AW;
    localparam int DW = ibs_pkg::DW;
    localparam int SW = ibs_pkg::SW;
    localparam int EW = 1 + AW + DW;
    localparam int CW = $clog2(WPS);
    localparam int LW = $clog2(ibs_pkg::FIFO_DEPTH) + 1;

    initial begin
        if (NSLV * WPS > (1 << AW) || NSLV > (1 << SW) || (1 << CW) != WPS || WPS < 2) begin
            $error("ibs_swap_lock slave count or area size out of range");
        end
    end

    typedef struct packed {
        ibs_pkg::ibs_st_t st;
        logic in_open;
        logic [LW-1:0] lcnt;
        logic in_busy;
        logic hw_busy;
        logic [CW-1:0] widx;
        logic [SW-1:0] oslv;
        logic [CW-1:0] ocnt;
        logic bout_valid;
        logic [DW-1:0] bout_data;
        logic bout_last;
        logic hst_ack;
        logic hst_err;
        logic [DW-1:0] hst_rdata;
        logic [NSLV-1:0] swap;
    } ibs_top_st_t;

    localparam ibs_top_st_t RST_VAL = '{
        st: ibs_pkg::ST_IDLE,
        swap: {NSLV{ibs_pkg::SWAP_RST}},
        default: '0
    };

    ibs_top_st_t q_r, q_nxt;
    logic [DW-1:0] in_mem_r [NSLV*WPS];
    logic [DW-1:0] out_mem_r [NSLV*WPS];

    // Byte exchange of one word when enabled.
    function automatic logic [DW-1:0] ibs_swap(input logic en, input logic [DW-1:0] w);
        ibs_swap = en ? {w[7:0], w[15:8]} : w;
    endfunction : ibs_swap

    // Word address of a slave's area entry.
    function automatic logic [AW-1:0] ibs_addr(input logic [SW-1:0] s, input logic [CW-1:0] i);
        ibs_addr = AW'({s, i});
    endfunction : ibs_addr

    ////////////////////////////////////////////////////////////////////////////
    // Input path: words are swapped before buffering so the area only ever
    // holds final byte order.
    logic fin_ready, fout_valid, fout_ready, bin_take, drain;
    logic [EW-1:0] fin_data, fout_data;
    logic hst_take, hst_prot, hst_stall, hst_refuse, out_wr_prot;
    logic start_now, out_hold;
    logic [SW-1:0] start_slv;
    logic [DW-1:0] start_word, next_word;

    assign fin_data = {i_bin_last, ibs_addr(i_bin_slave, q_r.widx),
                       ibs_swap(q_r.swap[i_bin_slave], i_bin_data)}; // R1 R11
    assign bin_take = i_bin_valid && fin_ready;
    // The input area has one port; a host read of it takes the cycle.
    assign fout_ready = !(hst_take && !i_hst_wr && i_hst_area == ibs_pkg::AREA_IN);
    assign drain = fout_valid && fout_ready;
    assign o_bin_ready = fin_ready;

    ibs_fifo #(.WIDTH(EW), .DEPTH(ibs_pkg::FIFO_DEPTH)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_in_valid(i_bin_valid),
        .i_in_data(fin_data),
        .o_in_ready(fin_ready),
        .o_out_valid(fout_valid),
        .o_out_data(fout_data),
        .i_out_ready(fout_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Host access classification and stall.
    always_comb begin
        hst_prot = (i_hst_kind == ibs_pkg::KIND_REFRESH && i_consist_en)
                || (i_hst_kind == ibs_pkg::KIND_BLOCK && !i_consist_en); // R8
        hst_refuse = i_hst_kind == ibs_pkg::KIND_BLOCK && i_consist_en; // R10
        hst_stall = hst_prot && !i_hst_wr && i_hst_area == ibs_pkg::AREA_IN
                 && q_r.in_busy; // R6
        hst_take = i_hst_req && !q_r.hst_ack && !hst_stall;
        out_wr_prot = hst_take && !hst_refuse && hst_prot && i_hst_wr
                   && i_hst_area == ibs_pkg::AREA_OUT; // R7
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output sender: a protected host write in flight, or landing this cycle,
    // holds the start so a send never begins on a half-written area.
    assign out_hold = q_r.hw_busy || out_wr_prot; // R7
    assign start_now = !out_hold && ((q_r.st == ibs_pkg::ST_IDLE && i_bout_req)
                                  || q_r.st == ibs_pkg::ST_HOLD);
    assign start_slv = (q_r.st == ibs_pkg::ST_IDLE) ? i_bout_slave : q_r.oslv;
    assign start_word = ibs_swap(q_r.swap[start_slv], out_mem_r[ibs_addr(start_slv, '0)]); // R1
    assign next_word = ibs_swap(q_r.swap[q_r.oslv], out_mem_r[ibs_addr(q_r.oslv, q_r.ocnt)]);

    ////////////////////////////////////////////////////////////////////////////
    // Next state of all control.
    always_comb begin
        q_nxt = q_r;
        q_nxt.hst_ack = hst_take;
        q_nxt.hst_err = hst_take && hst_refuse; // R10
        if (i_cfg_we) begin
            q_nxt.swap[i_cfg_slave] = i_cfg_swap; // R2
        end
        // Busy from the first accepted word until the last word is stored.
        if (bin_take) begin
            q_nxt.widx = i_bin_last ? '0 : q_r.widx + 1'b1;
            q_nxt.in_open = !i_bin_last;
        end
        q_nxt.lcnt = q_r.lcnt + LW'(bin_take && i_bin_last) - LW'(drain && fout_data[EW-1]);
        q_nxt.in_busy = q_nxt.in_open || q_nxt.lcnt != '0; // R5 R11
        if (hst_take && !hst_refuse) begin
            if (i_hst_area == ibs_pkg::AREA_IN) begin
                q_nxt.hst_rdata = in_mem_r[i_hst_addr];
            end else begin
                q_nxt.hst_rdata = out_mem_r[i_hst_addr];
            end
        end
        if (out_wr_prot) begin
            q_nxt.hw_busy = !i_hst_last; // R7
        end
        case (q_r.st)
            ibs_pkg::ST_IDLE: begin
                if (i_bout_req) begin
                    q_nxt.oslv = i_bout_slave;
                    q_nxt.st = ibs_pkg::ST_HOLD;
                end
            end
            ibs_pkg::ST_HOLD: begin
                q_nxt.st = ibs_pkg::ST_HOLD;
            end
            ibs_pkg::ST_SEND: begin
                if (i_bout_ready) begin
                    if (q_r.bout_last) begin
                        q_nxt.bout_valid = 1'b0;
                        q_nxt.bout_last = 1'b0;
                        q_nxt.st = ibs_pkg::ST_IDLE;
                    end else begin
                        q_nxt.bout_data = next_word; // R1 R11
                        q_nxt.bout_last = q_r.ocnt == CW'(WPS - 1);
                        q_nxt.ocnt = q_r.ocnt + 1'b1;
                    end
                end
            end
            default: begin
                q_nxt.st = ibs_pkg::ST_IDLE;
            end
        endcase
        if (start_now) begin
            q_nxt.st = ibs_pkg::ST_SEND;
            q_nxt.oslv = start_slv;
            q_nxt.bout_valid = 1'b1;
            q_nxt.bout_data = start_word;
            q_nxt.bout_last = 1'b0;
            q_nxt.ocnt = CW'(1);
        end
    end

    // State register; swap bits come up cleared.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q_r <= RST_VAL; // R3
        end else begin
            q_r <= q_nxt;
        end
    end

    // Area storage: drained input words and host output writes.
    always_ff @(posedge i_sys_clk) begin
        if (drain) begin
            in_mem_r[fout_data[EW-2:DW]] <= fout_data[DW-1:0]; // R11
        end
        if (hst_take && !hst_refuse && i_hst_wr && i_hst_area == ibs_pkg::AREA_OUT) begin
            out_mem_r[i_hst_addr] <= i_hst_wdata;
        end
    end

    // Outputs straight from the state register.
    assign o_bout_valid = q_r.bout_valid;
    assign o_bout_data = q_r.bout_data;
    assign o_bout_last = q_r.bout_last;
    assign o_hst_ack = q_r.hst_ack;
    assign o_hst_err = q_r.hst_err;
    assign o_hst_rdata = q_r.hst_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the control state.
    property p_swap_rst;
        @(posedge i_sys_clk) i_reset |=> q_r.swap == {NSLV{ibs_pkg::SWAP_RST}};
    endproperty
    a_swap_rst: assert property (p_swap_rst) // R3
        else $error("swap bits not cleared by reset");

    property p_in_stall;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_hst_req && hst_prot && !i_hst_wr && i_hst_area == ibs_pkg::AREA_IN && q_r.in_busy)
        |=> !q_r.hst_ack;
    endproperty
    a_in_stall: assert property (p_in_stall) // R6
        else $error("protected input read answered during transfer");

    property p_out_hold;
        @(posedge i_sys_clk) disable iff (i_reset)
        (q_r.hw_busy && q_r.st != ibs_pkg::ST_SEND) |=> !q_r.bout_valid;
    endproperty
    a_out_hold: assert property (p_out_hold) // R7
        else $error("output sent during protected host write");

    property p_free;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_hst_req && !q_r.hst_ack
         && (i_hst_kind == ibs_pkg::KIND_MOVE || i_hst_kind == ibs_pkg::KIND_DIRECT))
        |=> q_r.hst_ack;
    endproperty
    a_free: assert property (p_free) // R8
        else $error("unprotected access was delayed");

    property p_refuse;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_hst_req && !q_r.hst_ack && i_hst_kind == ibs_pkg::KIND_BLOCK && i_consist_en)
        |=> q_r.hst_err;
    endproperty
    a_refuse: assert property (p_refuse) // R10
        else $error("block access not refused");

    property p_err_ack;
        @(posedge i_sys_clk) disable iff (i_reset) q_r.hst_err |-> q_r.hst_ack;
    endproperty
    a_err_ack: assert property (p_err_ack) // R10
        else $error("refusal without answer");

    property p_last_valid;
        @(posedge i_sys_clk) disable iff (i_reset) q_r.bout_last |-> q_r.bout_valid;
    endproperty
    a_last_valid: assert property (p_last_valid) // R7
        else $error("last marker without valid word");
endmodule : ibs_swap_lock
`default_nettype wire

/* File: verif/ibs_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bus-side stand-in that feeds input words to the block.
module ibs_bus_model (
    // Clock.
    input wire logic i_sys_clk,
    // Input words toward the block.
    output logic o_valid,
    output logic [15:0] o_data,
    output logic o_last,
    input wire logic i_ready
);
    // Idle state at time zero.
    initial begin
        o_valid = 1'b0;
        o_data = 16'h0000;
        o_last = 1'b0;
    end
    // Offers one word until taken; the data line then shows its inverse.
    task automatic send(input logic [15:0] d, input logic l);
        int n;
        @(negedge i_sys_clk);
        o_valid = 1'b1;
        o_data = d;
        o_last = l;
        for (n = 0; n < 60 && i_ready !== 1'b1; n++) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        o_valid = 1'b0;
        o_data = ~d;
        o_last = ~l;
    endtask : send
endmodule : ibs_bus_model
`default_nettype wire

/* File: verif/tb_io_byte_swap_consistency.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the swap and interlock block.
module tb_io_byte_swap_consistency;
    logic clk = 1'b0, rst = 1'b1, cons = 1'b0, cwe = 1'b0, csw = 1'b0;
    logic [5:0] csl = 6'h00, isl = 6'h00, osl = 6'h00;
    logic bv, bl, br, oreq = 1'b0, ov, ol, req = 1'b0, wr = 1'b0, ar = 1'b0;
    logic hl = 1'b1, ack, err, seen;
    logic [1:0] kd = 2'h0;
    logic [9:0] ad = 10'h000;
    logic [15:0] bd, od, wd = 16'h0000, rd, got;
    int num_errors = 0, total_checks = 0, n;
    // Clock at 25 MHz.
    always #20 clk = ~clk;
    ibs_bus_model bus (.i_sys_clk(clk), .o_valid(bv), .o_data(bd), .o_last(bl), .i_ready(br));
    ibs_swap_lock dut (.i_sys_clk(clk), .i_reset(rst), .i_consist_en(cons), .i_cfg_we(cwe),
        .i_cfg_slave(csl), .i_cfg_swap(csw), .i_bin_valid(bv), .i_bin_slave(isl),
        .i_bin_data(bd), .i_bin_last(bl), .o_bin_ready(br), .i_bout_req(oreq),
        .i_bout_slave(osl), .i_bout_ready(1'b1), .o_bout_valid(ov), .o_bout_data(od),
        .o_bout_last(ol), .i_hst_req(req), .i_hst_kind(kd), .i_hst_wr(wr), .i_hst_area(ar),
        .i_hst_addr(ad), .i_hst_wdata(wd), .i_hst_last(hl), .o_hst_ack(ack), .o_hst_err(err),
        .o_hst_rdata(rd));
    // Compares one value and counts it.
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // Holds a host request until answered; a lost answer counts as a mismatch.
    task automatic hst(input logic [1:0] k, input logic w, input logic a, input logic [9:0] d,
                       input logic [15:0] v);
        @(negedge clk);
        {req, kd, wr, ar, ad, wd} = {1'b1, k, w, a, d, v};
        for (n = 0; n < 200 && ack !== 1'b1 && err !== 1'b1; n++) @(negedge clk);
        if (n == 200) begin
            chk(16'h0bad, 16'h0000);
            summarize();
        end
        got = rd;
        req = 1'b0;
        wd = ~v;
    endtask : hst
    // Writes one swap bit.
    task automatic cfg(input logic [5:0] s, input logic b);
        @(negedge clk);
        {cwe, csl, csw} = {1'b1, s, b};
        @(negedge clk);
        cwe = 1'b0;
    endtask : cfg
    // Default is unswapped; swap is per slave.
    task automatic t_swap();
        isl = 6'h01;
        bus.send(16'h1234, 1'b1);
        hst(ibs_pkg::KIND_REFRESH, 1'b0, ibs_pkg::AREA_IN, 10'h010, 16'h0000);
        chk(got, 16'h1234);
        cfg(6'h02, 1'b1);
        isl = 6'h02;
        bus.send(16'h1234, 1'b1);
        isl = 6'h03;
        bus.send(16'habcd, 1'b1);
        hst(ibs_pkg::KIND_REFRESH, 1'b0, ibs_pkg::AREA_IN, 10'h020, 16'h0000);
        chk(got, 16'h3412);
        hst(ibs_pkg::KIND_REFRESH, 1'b0, ibs_pkg::AREA_IN, 10'h030, 16'h0000);
        chk(got, 16'habcd);
        $display("test swap done");
    endtask : t_swap
    // Output of a swapped slave leaves swapped, after the host write ends.
    task automatic t_out();
        hst(ibs_pkg::KIND_REFRESH, 1'b1, ibs_pkg::AREA_OUT, 10'h020, 16'h5678);
        @(negedge clk);
        {oreq, osl} = {1'b1, 6'h02};
        for (n = 0; n < 100 && ov !== 1'b1; n++) @(negedge clk);
        oreq = 1'b0;
        chk(od, 16'h7856);
        for (n = 0; n < 100 && ol !== 1'b1; n++) @(negedge clk);
        chk({15'h0000, ol}, 16'h0001);
        $display("test output done");
    endtask : t_out
    // With consistency on: block refused, move free, refresh read stalls.
    task automatic t_lock();
        cons = 1'b1;
        hst(ibs_pkg::KIND_BLOCK, 1'b0, ibs_pkg::AREA_IN, 10'h030, 16'h0000);
        chk({15'h0000, err}, 16'h0001);
        isl = 6'h03;
        bus.send(16'h1111, 1'b0);
        hst(ibs_pkg::KIND_MOVE, 1'b0, ibs_pkg::AREA_IN, 10'h030, 16'h0000);
        chk({15'h0000, err}, 16'h0000);
        chk(got, 16'h1111);
        @(negedge clk);
        {req, kd, wr, ar, ad} = {1'b1, ibs_pkg::KIND_REFRESH, 1'b0, ibs_pkg::AREA_IN, 10'h031};
        seen = 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (ack === 1'b1) seen = 1'b1;
        end
        chk({15'h0000, seen}, 16'h0000);
        bus.send(16'h2222, 1'b1);
        hst(ibs_pkg::KIND_REFRESH, 1'b0, ibs_pkg::AREA_IN, 10'h031, 16'h0000);
        chk(got, 16'h2222);
        // Output send waits while a protected host write is open.
        hl = 1'b0;
        hst(ibs_pkg::KIND_REFRESH, 1'b1, ibs_pkg::AREA_OUT, 10'h020, 16'h9abc);
        hl = 1'b1;
        {oreq, osl} = {1'b1, 6'h02};
        seen = 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (ov === 1'b1) seen = 1'b1;
        end
        chk({15'h0000, seen}, 16'h0000);
        hst(ibs_pkg::KIND_REFRESH, 1'b1, ibs_pkg::AREA_OUT, 10'h021, 16'h0001);
        for (n = 0; n < 100 && ov !== 1'b1; n++) @(negedge clk);
        oreq = 1'b0;
        chk(od, 16'hbc9a);
        $display("test lock done");
    endtask : t_lock
    // Main sequence with reset held for 20 cycles.
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_swap();
        t_out();
        t_lock();
        summarize();
    end
endmodule : tb_io_byte_swap_consistency
`default_nettype wire
